/* src/fsr_regs.sv */
// FEC status, report and event register bank
`timescale 1ns/100ps
// Summary of operation
// R1 - A 10-bit read-only count of corrupted blocks reads low byte at 0337 and bits 9..8 at 0338.
// R2 - The decoder start pattern at 0340 is read/write, 8 bits, resets to 1D and drives the decoder.
// R3 - Each block report is 5 bits: 00 none, 01..10 bytes corrected, 1F uncorrectable.
// R4 - Ground block A/B reports read at 0342/0343 and orbit block A/B reports at 0344/0345.
// R5 - The 2-bit path choice at 0346 reads 00 for orbit and 01 for ground.
// R6 - The 5-bit enable at 0350 resets to 00 and passes a request only where its bit is one.
// R7 - The 5-bit pending vector at 0351 resets to 00; writing zero to a bit clears it.
// R8 - Bit 4 window done, bit 3 orbit B rate, bit 2 orbit A rate, bit 1 ground rate, bit 0 mgmt.
// R9 - Any write to 0332 pulses a start of the block counter, which stays idle after reset.
// R10 - The counting window is 16, 64, 256 or 1024 blocks and its end raises the done event.
// R11 - Each fresh rate result from the decoders sets its own pending bit.
// R12 - The request output is high while any pending bit is set together with its enable bit.
// R13 - An event in the same cycle as a software clear of its bit leaves the bit set.
module fsr_regs (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Register port behind the two-wire control interface
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Decoder status inputs
    input wire fsr_pkg::fsr_events_type events_i,
    input wire logic block_done_i,
    input wire logic block_bad_i,
    input wire fsr_pkg::fsr_report_type ground_a_i,
    input wire fsr_pkg::fsr_report_type ground_b_i,
    input wire fsr_pkg::fsr_report_type orbit_a_i,
    input wire fsr_pkg::fsr_report_type orbit_b_i,
    input wire logic path_valid_i,
    input wire logic [1:0] path_choice_i,
    // Outputs to the decoder and host
    output logic [7:0] decoder_start_pattern_o,
    output logic terr_sat_combine_o,
    output logic force_preamble_o,
    output logic irq_o
);
    logic [7:0] pattern_q, pattern_d;
    logic [3:0] config_q, config_d;
    logic [4:0] enable_q, enable_d;
    logic [4:0] pending_q, pending_d;
    logic [4:0] gnd_a_q, gnd_a_d, gnd_b_q, gnd_b_d;
    logic [4:0] orb_a_q, orb_a_d, orb_b_q, orb_b_d;
    logic [1:0] path_q, path_d;
    logic [7:0] rdata_q, rdata_d;
    logic irq_q, irq_d;
    logic start_pulse;
    logic trigger_single;
    logic window_done;
    logic [9:0] corrupt_count;
    logic [4:0] event_vec;
    logic [4:0] keep_mask;

    // ****************************************
    // Block error counter
    // ****************************************
    assign start_pulse = reg_wr_i && reg_addr_i == fsr_pkg::ADDR_COUNT_TRIGGER; // see R9
    assign trigger_single = reg_wdata_i[fsr_pkg::TRIG_SINGLE_BIT];

    fsr_block_counter u_counter (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .start_i(start_pulse),
        .single_i(trigger_single),
        .window_sel_i(config_q[fsr_pkg::CFG_WINDOW_LSB +: 2]),
        .block_done_i(block_done_i),
        .block_bad_i(block_bad_i),
        .corrupt_block_count_o(corrupt_count),
        .error_window_done_o(window_done)
    );

    // ****************************************
    // Event vector and pending bits
    // ****************************************
    always_comb begin
        event_vec = 5'h00; // see R8
        event_vec[fsr_pkg::EV_WINDOW_DONE] = window_done;
        event_vec[fsr_pkg::EV_ORBIT_B] = events_i.orbit_b_rate_ready; // see R11
        event_vec[fsr_pkg::EV_ORBIT_A] = events_i.orbit_a_rate_ready;
        event_vec[fsr_pkg::EV_GROUND] = events_i.ground_rate_ready;
        event_vec[fsr_pkg::EV_MGMT] = events_i.mgmt_request;
    end

    always_comb begin
        keep_mask = 5'h1f;
        if (reg_wr_i && reg_addr_i == fsr_pkg::ADDR_EVENT_PENDING) begin
            keep_mask = reg_wdata_i[4:0]; // see R7
        end
        // Set beats clear, and the enable does not gate setting
        pending_d = (pending_q & keep_mask) | event_vec; // see R13
        irq_d = |(pending_d & enable_d);
    end

    // ****************************************
    // Writable registers and captured reports
    // ****************************************
    always_comb begin
        pattern_d = pattern_q;
        config_d = config_q;
        enable_d = enable_q;
        if (reg_wr_i) begin
            if (reg_addr_i == fsr_pkg::ADDR_START_PATTERN) begin
                pattern_d = reg_wdata_i; // see R2
            end else if (reg_addr_i == fsr_pkg::ADDR_DECODER_CONFIG) begin
                config_d = reg_wdata_i[3:0];
            end else if (reg_addr_i == fsr_pkg::ADDR_EVENT_ENABLE) begin
                enable_d = reg_wdata_i[4:0]; // see R6
            end
        end
        gnd_a_d = ground_a_i.valid ? ground_a_i.code : gnd_a_q; // see R3
        gnd_b_d = ground_b_i.valid ? ground_b_i.code : gnd_b_q;
        orb_a_d = orbit_a_i.valid ? orbit_a_i.code : orb_a_q;
        orb_b_d = orbit_b_i.valid ? orbit_b_i.code : orb_b_q;
        path_d = path_valid_i ? path_choice_i : path_q; // see R5
    end

    // ****************************************
    // Read mux
    // ****************************************
    always_comb begin
        rdata_d = 8'h00;
        if (reg_addr_i == fsr_pkg::ADDR_CORRUPT_LOW) begin
            rdata_d = corrupt_count[7:0]; // see R1
        end else if (reg_addr_i == fsr_pkg::ADDR_CORRUPT_HIGH) begin
            rdata_d = {6'h00, corrupt_count[9:8]};
        end else if (reg_addr_i == fsr_pkg::ADDR_START_PATTERN) begin
            rdata_d = pattern_q;
        end else if (reg_addr_i == fsr_pkg::ADDR_DECODER_CONFIG) begin
            rdata_d = {4'h0, config_q};
        end else if (reg_addr_i == fsr_pkg::ADDR_GROUND_A) begin
            rdata_d = {3'h0, gnd_a_q}; // see R4
        end else if (reg_addr_i == fsr_pkg::ADDR_GROUND_B) begin
            rdata_d = {3'h0, gnd_b_q};
        end else if (reg_addr_i == fsr_pkg::ADDR_ORBIT_A) begin
            rdata_d = {3'h0, orb_a_q};
        end else if (reg_addr_i == fsr_pkg::ADDR_ORBIT_B) begin
            rdata_d = {3'h0, orb_b_q};
        end else if (reg_addr_i == fsr_pkg::ADDR_PATH_CHOICE) begin
            rdata_d = {6'h00, path_q};
        end else if (reg_addr_i == fsr_pkg::ADDR_EVENT_ENABLE) begin
            rdata_d = {3'h0, enable_q};
        end else if (reg_addr_i == fsr_pkg::ADDR_EVENT_PENDING) begin
            rdata_d = {3'h0, pending_q};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pattern_q <= fsr_pkg::RST_START_PATTERN;
            config_q <= fsr_pkg::RST_DECODER_CONFIG;
            enable_q <= fsr_pkg::RST_EVENT_ENABLE;
            pending_q <= fsr_pkg::RST_EVENT_PENDING;
            gnd_a_q <= fsr_pkg::ERR_NONE;
            gnd_b_q <= fsr_pkg::ERR_NONE;
            orb_a_q <= fsr_pkg::ERR_NONE;
            orb_b_q <= fsr_pkg::ERR_NONE;
            path_q <= fsr_pkg::PATH_ORBIT;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
        end else begin
            pattern_q <= pattern_d;
            config_q <= config_d;
            enable_q <= enable_d;
            pending_q <= pending_d;
            gnd_a_q <= gnd_a_d;
            gnd_b_q <= gnd_b_d;
            orb_a_q <= orb_a_d;
            orb_b_q <= orb_b_d;
            path_q <= path_d;
            rdata_q <= rdata_d;
            irq_q <= irq_d; // see R12
        end
    end

    assign reg_rdata_o = rdata_q;
    assign decoder_start_pattern_o = pattern_q; // see R2
    assign terr_sat_combine_o = config_q[1];
    assign force_preamble_o = config_q[0];
    assign irq_o = irq_q;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_pending_write;
        reg_wr_i && reg_addr_i == fsr_pkg::ADDR_EVENT_PENDING;
    endsequence

    a_irq_tracks_mask: assert property ( // see R12
        irq_o == |(pending_q & enable_q))
        else $error("request output disagrees with pending and enable");
    a_event_sets_bit: assert property ( // see R13
        s_pending_write ##0 events_i.ground_rate_ready |=> pending_q[fsr_pkg::EV_GROUND])
        else $error("event lost against a clear");
    a_zero_clears_all: assert property ( // see R7
        s_pending_write ##0 (reg_wdata_i[4:0] == 5'h00 && event_vec == 5'h00)
        |=> pending_q == 5'h00)
        else $error("zero write did not clear pending");
    a_mask_blocks: assert property ( // see R6
        enable_q == 5'h00 && !(reg_wr_i && reg_addr_i == fsr_pkg::ADDR_EVENT_ENABLE)
        |=> !irq_o)
        else $error("request passed a closed enable");
    a_pattern_write: assert property ( // see R2
        reg_wr_i && reg_addr_i == fsr_pkg::ADDR_START_PATTERN
        |=> decoder_start_pattern_o == $past(reg_wdata_i))
        else $error("start pattern not written");
    a_window_bit_set: assert property ( // see R10
        window_done |=> pending_q[fsr_pkg::EV_WINDOW_DONE])
        else $error("window done did not set pending");
    a_path_readback: assert property ( // see R5
        reg_addr_i == fsr_pkg::ADDR_PATH_CHOICE |=> reg_rdata_o == {6'h00, $past(path_q)})
        else $error("path choice readback wrong");
    a_count_high_read: assert property ( // see R1
        reg_addr_i == fsr_pkg::ADDR_CORRUPT_HIGH |=> reg_rdata_o[7:2] == 6'h00)
        else $error("count high byte has stray bits");
    a_trigger_pulse: assert property ( // see R9
        start_pulse |=> u_counter.state_q == fsr_pkg::WIN_RUN)
        else $error("trigger write did not start the counter");
endmodule

/* src/fsr_pkg.sv */
// Constants and types for the FEC status and event register bank
package fsr_pkg;
    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [15:0] ADDR_CORRUPT_LOW = 16'h0337;
    localparam logic [15:0] ADDR_CORRUPT_HIGH = 16'h0338;
    localparam logic [15:0] ADDR_START_PATTERN = 16'h0340;
    localparam logic [15:0] ADDR_GROUND_A = 16'h0342;
    localparam logic [15:0] ADDR_GROUND_B = 16'h0343;
    localparam logic [15:0] ADDR_ORBIT_A = 16'h0344;
    localparam logic [15:0] ADDR_ORBIT_B = 16'h0345;
    localparam logic [15:0] ADDR_PATH_CHOICE = 16'h0346;
    localparam logic [15:0] ADDR_EVENT_ENABLE = 16'h0350;
    localparam logic [15:0] ADDR_EVENT_PENDING = 16'h0351;
    localparam logic [15:0] ADDR_DECODER_CONFIG = 16'h0331;
    localparam logic [15:0] ADDR_COUNT_TRIGGER = 16'h0332;

    // ****************************************
    // Reset values and field positions
    // ****************************************
    localparam logic [7:0] RST_START_PATTERN = 8'h1d;
    localparam logic [4:0] RST_EVENT_ENABLE = 5'h00;
    localparam logic [4:0] RST_EVENT_PENDING = 5'h00;
    localparam logic [3:0] RST_DECODER_CONFIG = 4'h3;
    localparam int CFG_WINDOW_LSB = 2;
    localparam int TRIG_SINGLE_BIT = 0;
    localparam int EV_WINDOW_DONE = 4;
    localparam int EV_ORBIT_B = 3;
    localparam int EV_ORBIT_A = 2;
    localparam int EV_GROUND = 1;
    localparam int EV_MGMT = 0;

    // ****************************************
    // Error report codes and path codes
    // ****************************************
    localparam logic [4:0] ERR_NONE = 5'h00;
    localparam logic [4:0] ERR_MAX_FIXED = 5'h10;
    localparam logic [4:0] ERR_UNFIXABLE = 5'h1f;
    localparam logic [1:0] PATH_ORBIT = 2'h0;
    localparam logic [1:0] PATH_GROUND = 2'h1;

    // ****************************************
    // Window lengths in blocks, minus one
    // ****************************************
    localparam logic [9:0] WIN_LAST_16 = 10'h00f;
    localparam logic [9:0] WIN_LAST_64 = 10'h03f;
    localparam logic [9:0] WIN_LAST_256 = 10'h0ff;
    localparam logic [9:0] WIN_LAST_1024 = 10'h3ff;
    localparam logic [9:0] COUNT_MAX = 10'h3ff;

    typedef enum logic [1:0] {
        WIN_IDLE = 2'b00,
        WIN_RUN = 2'b01,
        WIN_HOLD = 2'b11
    } fsr_win_state_type;

    // Event pulses from the decoder datapaths
    typedef struct packed {
        logic mgmt_request;
        logic ground_rate_ready;
        logic orbit_a_rate_ready;
        logic orbit_b_rate_ready;
    } fsr_events_type;

    // One per-block error report with its strobe
    typedef struct packed {
        logic valid;
        logic [4:0] code;
    } fsr_report_type;
endpackage

/* src/fsr_block_counter.sv */
// Corrupted block counter over a programmable window of blocks
`timescale 1ns/100ps
module fsr_block_counter (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    // Control
    input wire logic start_i,
    input wire logic single_i,
    input wire logic [1:0] window_sel_i,
    // Block stream
    input wire logic block_done_i,
    input wire logic block_bad_i,
    // Results
    output logic [9:0] corrupt_block_count_o,
    output logic error_window_done_o
);
    fsr_pkg::fsr_win_state_type state_q, state_d;
    logic [9:0] blocks_q, blocks_d;
    logic [9:0] bad_q, bad_d;
    logic [9:0] result_q, result_d;
    logic done_q, done_d;
    logic single_q, single_d;
    logic [9:0] last_block;
    logic [9:0] bad_next;

    always_comb begin
        case (window_sel_i)
            2'b00: last_block = fsr_pkg::WIN_LAST_16;
            2'b01: last_block = fsr_pkg::WIN_LAST_64;
            2'b10: last_block = fsr_pkg::WIN_LAST_256;
            default: last_block = fsr_pkg::WIN_LAST_1024;
        endcase
    end

    // ****************************************
    // Window state machine
    // ****************************************
    always_comb begin
        state_d = state_q;
        blocks_d = blocks_q;
        bad_d = bad_q;
        result_d = result_q;
        done_d = 1'b0;
        single_d = single_q;
        // Saturate so a fully bad 1024 window reads as the top value
        bad_next = (block_bad_i && bad_q != fsr_pkg::COUNT_MAX) ? bad_q + 10'h001 : bad_q;
        if (start_i) begin // see R9
            state_d = fsr_pkg::WIN_RUN;
            blocks_d = 10'h000;
            bad_d = 10'h000;
            single_d = single_i;
        end else begin
            case (state_q)
                fsr_pkg::WIN_RUN: begin
                    if (block_done_i) begin
                        if (blocks_q == last_block) begin // see R10
                            result_d = bad_next;
                            done_d = 1'b1;
                            blocks_d = 10'h000;
                            bad_d = 10'h000;
                            state_d = single_q ? fsr_pkg::WIN_HOLD : fsr_pkg::WIN_RUN;
                        end else begin
                            blocks_d = blocks_q + 10'h001;
                            bad_d = bad_next;
                        end
                    end
                end
                default: begin
                    state_d = state_q;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q <= fsr_pkg::WIN_IDLE;
            blocks_q <= 10'h000;
            bad_q <= 10'h000;
            result_q <= 10'h000;
            done_q <= 1'b0;
            single_q <= 1'b1;
        end else begin
            state_q <= state_d;
            blocks_q <= blocks_d;
            bad_q <= bad_d;
            result_q <= result_d;
            done_q <= done_d;
            single_q <= single_d;
        end
    end

    assign corrupt_block_count_o = result_q; // see R1
    assign error_window_done_o = done_q;

    // ****************************************
    // Checks
    // ****************************************
    a_idle_until_start: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R9
        state_q == fsr_pkg::WIN_IDLE && !start_i |=> state_q == fsr_pkg::WIN_IDLE)
        else $error("counter left idle without a trigger");
    a_window_end_done: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R10
        state_q == fsr_pkg::WIN_RUN && !start_i && block_done_i && blocks_q == last_block
        |=> error_window_done_o)
        else $error("window end did not raise done");
    a_done_only_run: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // see R10
        error_window_done_o |-> $past(state_q) == fsr_pkg::WIN_RUN && $past(block_done_i))
        else $error("done without a finished block");
endmodule

/* dv/fsr_host_model.sv */
// Host model that reaches the register bank over the control port
`timescale 1ns/100ps
module fsr_host_model (
    // Clock
    input wire logic sys_clk_i,
    // Register port
    output logic [15:0] reg_addr_o,
    output logic reg_wr_o,
    output logic [7:0] reg_wdata_o,
    input wire logic [7:0] reg_rdata_i
);
    initial begin
        reg_addr_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // ****************************************
    // Byte access
    // ****************************************
    // Strobe lasts one edge; released data shows its inverse
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        reg_wr_o <= 1'b1;
        reg_wdata_o <= d;
        @(posedge sys_clk_i);
        reg_wr_o <= 1'b0;
        reg_wdata_o <= ~d;
    endtask

    // Read data follows the address by one edge
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        reg_addr_o <= a;
        @(posedge sys_clk_i);
        #1;
        d = reg_rdata_i;
    endtask

    // ****************************************
    // Software duties
    // ****************************************
    // Zero written to each bit that is to be dropped
    task automatic clear_pending(input logic [4:0] bits);
        wr_reg(fsr_pkg::ADDR_EVENT_PENDING, {3'h0, ~bits});
    endtask

    // Any write to the trigger byte starts a window
    task automatic start_count(input logic single);
        wr_reg(fsr_pkg::ADDR_COUNT_TRIGGER, {7'h00, single});
    endtask
endmodule

/* dv/tb.sv */
// Self-checking bench for the status and event register bank
`timescale 1ns/100ps
module tb;
    logic sys_clk_i;
    logic sys_rst_i;
    logic [15:0] reg_addr;
    logic reg_wr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    fsr_pkg::fsr_events_type events;
    logic block_done;
    logic block_bad;
    fsr_pkg::fsr_report_type rep[4];
    logic path_valid;
    logic [1:0] path_choice;
    logic [7:0] pattern;
    logic combine;
    logic force_pre;
    logic irq;
    logic [31:0] seed;
    logic [31:0] r;
    logic [4:0] c;
    logic [9:0] e;
    int bad_cnt;
    int num_errors;
    int n_tests;

    fsr_host_model fsr_host_model_i (.sys_clk_i(sys_clk_i), .reg_addr_o(reg_addr),
        .reg_wr_o(reg_wr), .reg_wdata_o(reg_wdata), .reg_rdata_i(reg_rdata));

    fsr_regs fsr_regs_i (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
        .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .events_i(events), .block_done_i(block_done),
        .block_bad_i(block_bad), .ground_a_i(rep[0]), .ground_b_i(rep[1]),
        .orbit_a_i(rep[2]), .orbit_b_i(rep[3]), .path_valid_i(path_valid),
        .path_choice_i(path_choice), .decoder_start_pattern_o(pattern),
        .terr_sat_combine_o(combine), .force_preamble_o(force_pre), .irq_o(irq));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Legal report code: 0..16 bytes or uncorrectable
    function automatic logic [4:0] code_of(input logic [31:0] v);
        return (v[4:0] > 5'h10) ? fsr_pkg::ERR_UNFIXABLE : v[4:0];
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        fsr_host_model_i.rd_reg(a, d);
        check(16'(d), 16'(exp));
    endtask

    task automatic pulse_event(input logic [3:0] v);
        @(posedge sys_clk_i);
        events <= fsr_pkg::fsr_events_type'(v);
        @(posedge sys_clk_i);
        events <= '0;
    endtask

    task automatic send_blocks(input int n, input logic all_bad);
        logic bb;
        for (int b = 0; b < n; b++) begin
            r = rnd();
            bb = all_bad | r[0];
            bad_cnt += int'(bb);
            @(posedge sys_clk_i);
            block_done <= 1'b1;
            block_bad <= bb;
            @(posedge sys_clk_i);
            block_done <= 1'b0;
            block_bad <= ~bb;
        end
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ****************************************
    // Clock, reset and watchdog
    // ****************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        num_errors++;
        complete_run();
    end

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        seed = 32'h179b_76be;
        sys_rst_i = 1'b1;
        events = '0;
        block_done = 1'b0;
        block_bad = 1'b0;
        foreach (rep[i]) rep[i] = '0;
        path_valid = 1'b0;
        path_choice = 2'h0;
        num_errors = 0;
        n_tests = 0;
        repeat (10) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rchk(fsr_pkg::ADDR_START_PATTERN, 8'h1d);
        check(pattern, 8'h1d);
        rchk(fsr_pkg::ADDR_EVENT_ENABLE, 8'h00);
        rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h00);
        check(irq, 1'b0);
        $display("reset test done");
        repeat (4) begin
            r = rnd();
            fsr_host_model_i.wr_reg(fsr_pkg::ADDR_START_PATTERN, r[7:0]);
            #1;
            check(pattern, r[7:0]);
            rchk(fsr_pkg::ADDR_START_PATTERN, r[7:0]);
        end
        fsr_host_model_i.wr_reg(fsr_pkg::ADDR_GROUND_A, 8'hff);
        rchk(fsr_pkg::ADDR_GROUND_A, 8'h00);
        rchk(16'h0339, 8'h00);
        $display("pattern test done");
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 3; j++) begin
                c = (j == 0) ? fsr_pkg::ERR_UNFIXABLE : (j == 1) ? fsr_pkg::ERR_MAX_FIXED
                    : code_of(rnd());
                @(posedge sys_clk_i);
                rep[i] <= {1'b1, c};
                @(posedge sys_clk_i);
                rep[i].valid <= 1'b0;
                rchk(fsr_pkg::ADDR_GROUND_A + 16'(i), {3'h0, c});
            end
        end
        for (int j = 1; j >= 0; j--) begin
            @(posedge sys_clk_i);
            path_choice <= 2'(j);
            path_valid <= 1'b1;
            @(posedge sys_clk_i);
            path_valid <= 1'b0;
            rchk(fsr_pkg::ADDR_PATH_CHOICE, 8'(j));
        end
        $display("report test done");
        for (int k = 0; k < 4; k++) begin
            fsr_host_model_i.wr_reg(fsr_pkg::ADDR_EVENT_ENABLE, 8'h00);
            fsr_host_model_i.clear_pending(5'h1f);
            pulse_event(4'b1000 >> k);
            rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h01 << k);
            check(irq, 1'b0);
            fsr_host_model_i.wr_reg(fsr_pkg::ADDR_EVENT_ENABLE, {3'h0, ~(5'h01 << k)});
            #1;
            check(irq, 1'b0);
            fsr_host_model_i.wr_reg(fsr_pkg::ADDR_EVENT_ENABLE, {3'h0, 5'h01 << k});
            #1;
            check(irq, 1'b1);
            fsr_host_model_i.clear_pending(5'h01 << k);
            #1;
            check(irq, 1'b0);
            rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h00);
        end
        fork
            fsr_host_model_i.clear_pending(5'h02);
            pulse_event(4'b0100);
        join
        rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h02);
        pulse_event(4'hf);
        fsr_host_model_i.wr_reg(fsr_pkg::ADDR_EVENT_PENDING, 8'h00);
        rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h00);
        $display("event test done");
        send_blocks(20, 1'b1);
        repeat (4) @(posedge sys_clk_i);
        rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h00);
        fsr_host_model_i.wr_reg(fsr_pkg::ADDR_EVENT_ENABLE, 8'h10);
        for (int s = 0; s < 4; s++) begin
            r = rnd();
            fsr_host_model_i.wr_reg(fsr_pkg::ADDR_DECODER_CONFIG, {4'h0, 2'(s), r[1:0]});
            #1;
            check(combine, r[1]);
            check(force_pre, r[0]);
            fsr_host_model_i.clear_pending(5'h1f);
            fsr_host_model_i.start_count(1'b1);
            bad_cnt = 0;
            send_blocks(16 << (2 * s), s == 3);
            repeat (4) @(posedge sys_clk_i);
            e = (bad_cnt > 1023) ? 10'h3ff : 10'(bad_cnt);
            rchk(fsr_pkg::ADDR_CORRUPT_LOW, e[7:0]);
            rchk(fsr_pkg::ADDR_CORRUPT_HIGH, {6'h00, e[9:8]});
            rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h10);
            check(irq, 1'b1);
        end
        $display("counter test done");
        // Continuous windows restart at once; the second window is counted alone
        fsr_host_model_i.wr_reg(fsr_pkg::ADDR_DECODER_CONFIG, 8'h00);
        fsr_host_model_i.start_count(1'b0);
        send_blocks(16, 1'b0);
        fsr_host_model_i.clear_pending(5'h1f);
        bad_cnt = 0;
        send_blocks(16, 1'b0);
        repeat (4) @(posedge sys_clk_i);
        rchk(fsr_pkg::ADDR_CORRUPT_LOW, 8'(bad_cnt));
        rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h10);
        $display("continuous test done");
        // Second reset in mid-run
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rchk(fsr_pkg::ADDR_EVENT_PENDING, 8'h00);
        rchk(fsr_pkg::ADDR_CORRUPT_LOW, 8'h00);
        check(irq, 1'b0);
        check(pattern, 8'h1d);
        $display("second reset test done");
        complete_run();
    end
endmodule
